/* rtl/etc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "etc_params.svh"
module etc_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ext_tick_in,
    input wire logic global_irq_en,
    input wire logic cmp_irq_ack,
    input wire logic ovf_irq_ack,
    output logic cmp_irq_req,
    output logic ovf_irq_req,
    input wire logic port_out_value,
    input wire logic output_pin_direction_bit,
    output logic compare_output_pin_o,
    output logic compare_output_pin_oe_n
);
    // Bus state.
    logic wr_pend_q; // A write data phase is in progress.
    logic [7:0] wr_ofs_q; // Offset of that write.
    logic [31:0] hrdata_q; // Read data for the data phase.
    logic addr_ok; // Address phase accepted.
    // Control fields.
    logic [2:0] tick_source_select;
    logic [1:0] waveform_mode_field;
    logic [1:0] output_action_field;
    logic force_q; // Force request, one cycle after the write.
    // Counter and compare.
    logic [7:0] count_value;
    logic [7:0] cnt_d; // Counter value after a tick.
    logic [7:0] compare_value; // Active compare register.
    logic [7:0] cmp_buf_q; // Buffered compare value.
    etc_pkg::etc_dir_t dir_q; // Count direction.
    logic block_q; // Match blocked until the next tick.
    // Flags and enables.
    logic compare_flag;
    logic overflow_flag;
    logic compare_irq_enable;
    logic ovf_irq_en_q;
    // Decoded events.
    etc_pkg::etc_wave_t mode;
    logic tick, pwm, eq, match_ok, at_top, ovf_set, cmp_set;
    logic wr_ctrl, wr_cnt, wr_cmp, wr_flags, wr_en;
    logic [7:0] rd_byte;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    assign mode = etc_pkg::etc_wave_t'(waveform_mode_field);
    // PWM modes are the two odd encodings.
    assign pwm = (mode == etc_pkg::ETC_WG_PCPWM) || (mode == etc_pkg::ETC_WG_FAST);

    // The slave never waits and never errors.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign addr_ok = hsel && hready && htrans[1];

    // Write decode in the data phase.
    assign wr_ctrl = wr_pend_q && (wr_ofs_q == `ETC_OFS_CTRL);
    assign wr_cnt = wr_pend_q && (wr_ofs_q == `ETC_OFS_COUNT);
    assign wr_cmp = wr_pend_q && (wr_ofs_q == `ETC_OFS_COMPARE);
    assign wr_flags = wr_pend_q && (wr_ofs_q == `ETC_OFS_FLAGS);
    assign wr_en = wr_pend_q && (wr_ofs_q == `ETC_OFS_IRQEN);

    // Captures write address phases for the following data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_ofs_q <= `ETC_RST_BYTE;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            wr_ofs_q <= haddr[7:0];
        end
    end

    // Read mux; unmapped offsets read zero.
    always_comb begin
        case (haddr[7:0])
            `ETC_OFS_CTRL: rd_byte = {1'b0, output_action_field,
                                      waveform_mode_field, tick_source_select};
            `ETC_OFS_COUNT: rd_byte = count_value;
            `ETC_OFS_COMPARE: rd_byte = pwm ? cmp_buf_q : compare_value;
            `ETC_OFS_FLAGS: rd_byte = {6'h00, compare_flag, overflow_flag};
            `ETC_OFS_IRQEN: rd_byte = {6'h00, compare_irq_enable, ovf_irq_en_q};
            default: rd_byte = 8'h00;
        endcase
    end

    // Read data is sampled in the address phase and held after.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // Control register; tick source starts deselected.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_source_select <= 3'h0;
            waveform_mode_field <= 2'h0;
            output_action_field <= 2'h0;
        end else if (wr_ctrl) begin
            tick_source_select <= hwdata[`ETC_CS_MSB:`ETC_CS_LSB];
            waveform_mode_field <= hwdata[`ETC_WGM_MSB:`ETC_WGM_LSB];
            output_action_field <= hwdata[`ETC_COM_MSB:`ETC_COM_LSB];
        end
    end

    // Force is delayed one cycle so it sees the freshly written fields.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            force_q <= 1'b0;
        end else begin
            force_q <= wr_ctrl && hwdata[`ETC_FOC_BIT];
        end
    end

    // Tick source selection and prescaler.
    etc_tick_sel u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .sel(tick_source_select),
        .ext_tick_in(ext_tick_in),
        .tick(tick)
    );

    // Match evaluation, suppressed right after a counter write.
    assign eq = (count_value == compare_value);
    assign match_ok = tick && eq && !block_q;
    assign cmp_set = match_ok;
    // Top of the sequence where a buffered value may load.
    assign at_top = (count_value == `ETC_MAX) && (dir_q == etc_pkg::ETC_DIR_UP);

    // Next count by mode alone; action bits play no part.
    always_comb begin
        case (mode)
            etc_pkg::ETC_WG_CTC: begin
                cnt_d = match_ok ? `ETC_BOTTOM : count_value + 8'h01;
            end
            etc_pkg::ETC_WG_PCPWM: begin
                if (dir_q == etc_pkg::ETC_DIR_UP) begin
                    cnt_d = (count_value == `ETC_MAX) ? count_value - 8'h01
                                                      : count_value + 8'h01;
                end else begin
                    cnt_d = (count_value == `ETC_BOTTOM) ? count_value + 8'h01
                                                         : count_value - 8'h01;
                end
            end
            default: begin
                cnt_d = count_value + 8'h01;
            end
        endcase
    end

    // Counter; a software write overrides any tick.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_value <= `ETC_RST_BYTE;
        end else if (wr_cnt) begin
            count_value <= hwdata[7:0];
        end else if (tick) begin
            count_value <= cnt_d;
        end
    end

    // Direction turns at max and bottom in phase correct mode only.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_q <= etc_pkg::ETC_DIR_UP;
        end else if (mode != etc_pkg::ETC_WG_PCPWM) begin
            dir_q <= etc_pkg::ETC_DIR_UP;
        end else if (tick && !wr_cnt) begin
            case (dir_q)
                etc_pkg::ETC_DIR_UP: begin
                    if (count_value == `ETC_MAX) begin
                        dir_q <= etc_pkg::ETC_DIR_DOWN;
                    end
                end
                etc_pkg::ETC_DIR_DOWN: begin
                    if (count_value == `ETC_BOTTOM) begin
                        dir_q <= etc_pkg::ETC_DIR_UP;
                    end
                end
                default: dir_q <= etc_pkg::ETC_DIR_UP;
            endcase
        end
    end

    // Block is raised by a counter write and spent by the next tick.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            block_q <= 1'b0;
        end else if (wr_cnt) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // Compare buffer: direct writes outside PWM, load at top in PWM.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_buf_q <= `ETC_RST_BYTE;
            compare_value <= `ETC_RST_BYTE;
        end else begin
            if (wr_cmp) begin
                cmp_buf_q <= hwdata[7:0];
            end
            if (wr_cmp && !pwm) begin
                compare_value <= hwdata[7:0];
            end else if (pwm && tick && at_top) begin
                compare_value <= cmp_buf_q;
            end
        end
    end

    // Overflow: max to zero, or reaching bottom when counting down.
    always_comb begin
        if (mode == etc_pkg::ETC_WG_PCPWM) begin
            ovf_set = tick && !wr_cnt && (dir_q == etc_pkg::ETC_DIR_DOWN)
                      && (count_value == 8'h01);
        end else begin
            ovf_set = tick && !wr_cnt && (count_value == `ETC_MAX)
                      && (cnt_d == `ETC_BOTTOM);
        end
    end

    // Flags; a set in the same cycle as a clear wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            if (cmp_set) begin
                compare_flag <= 1'b1;
            end else if (cmp_irq_ack || (wr_flags && hwdata[`ETC_CMP_BIT])) begin
                compare_flag <= 1'b0;
            end
            if (ovf_set) begin
                overflow_flag <= 1'b1;
            end else if (ovf_irq_ack || (wr_flags && hwdata[`ETC_OVF_BIT])) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // Interrupt enables.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_irq_enable <= 1'b0;
            ovf_irq_en_q <= 1'b0;
        end else if (wr_en) begin
            compare_irq_enable <= hwdata[`ETC_CMP_BIT];
            ovf_irq_en_q <= hwdata[`ETC_OVF_BIT];
        end
    end

    // Requests go out only under the global enable.
    assign cmp_irq_req = compare_flag && compare_irq_enable && global_irq_en;
    assign ovf_irq_req = overflow_flag && ovf_irq_en_q && global_irq_en;

    // Output unit; force only in non-PWM modes, never setting the flag.
    etc_out_unit u_out (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(waveform_mode_field),
        .action(output_action_field),
        .match_evt(match_ok),
        .bottom_evt(tick && !wr_cnt && (mode == etc_pkg::ETC_WG_FAST)
                    && (count_value == `ETC_MAX)),
        .force_evt(force_q && !pwm),
        .dir_up(dir_q == etc_pkg::ETC_DIR_UP),
        .port_out_value(port_out_value),
        .output_pin_direction_bit(output_pin_direction_bit),
        .compare_output(),
        .pin_o(compare_output_pin_o),
        .pin_oe_n(compare_output_pin_oe_n)
    );

    stop_no_tick_a: assert property (
        (tick_source_select == 3'h0) |-> !tick)
        else $error("tick while source deselected");
    cnt_write_wins_a: assert property (
        wr_cnt |=> (count_value == $past(hwdata[7:0])))
        else $error("counter write lost");
    normal_inc_a: assert property (
        (tick && !wr_cnt && mode == etc_pkg::ETC_WG_NORMAL)
        |=> (count_value == $past(count_value) + 8'h01))
        else $error("normal mode did not increment");
    cmp_flag_set_a: assert property (
        (tick && eq && !block_q) |=> compare_flag)
        else $error("match did not set compare flag");
    match_block_a: assert property (
        (tick && block_q && !compare_flag) |=> !compare_flag)
        else $error("blocked match set the flag");
    cmp_irq_a: assert property (
        (cmp_set && compare_irq_enable && global_irq_en) |=> cmp_irq_req)
        else $error("compare request missing");
    flag_w1c_a: assert property (
        (wr_flags && hwdata[`ETC_CMP_BIT] && !cmp_set) |=> !compare_flag)
        else $error("written one did not clear flag");
    flag_w0_keep_a: assert property (
        (wr_flags && !hwdata[`ETC_CMP_BIT] && !cmp_irq_ack && compare_flag)
        |=> compare_flag)
        else $error("written zero cleared flag");
    ovf_normal_a: assert property (
        (tick && !wr_cnt && mode == etc_pkg::ETC_WG_NORMAL && count_value == `ETC_MAX)
        |=> (overflow_flag && count_value == `ETC_BOTTOM))
        else $error("overflow not set at wrap");
    ovf_ack_a: assert property (
        (ovf_irq_ack && !ovf_set) |=> !overflow_flag)
        else $error("overflow service did not clear flag");
    buf_hold_a: assert property (
        (pwm && !(tick && at_top)) |=> (compare_value == $past(compare_value)))
        else $error("active compare changed off top");
    pc_turn_a: assert property (
        (mode == etc_pkg::ETC_WG_PCPWM && tick && !wr_cnt && count_value == `ETC_MAX
         && dir_q == etc_pkg::ETC_DIR_UP) |=> (count_value == 8'hFE))
        else $error("phase correct did not turn at max");

    ctc_clear_c: cover property (match_ok && mode == etc_pkg::ETC_WG_CTC);
    buf_load_c: cover property (pwm && tick && at_top && cmp_buf_q != compare_value);
    force_c: cover property (force_q && !pwm);
    pc_bottom_c: cover property (ovf_set && mode == etc_pkg::ETC_WG_PCPWM);
endmodule
`default_nettype wire

/* shared/etc_params.svh */
`ifndef ETC_PARAMS_SVH
`define ETC_PARAMS_SVH
// Register byte offsets.
`define ETC_OFS_CTRL 8'h00
`define ETC_OFS_COUNT 8'h04
`define ETC_OFS_COMPARE 8'h08
`define ETC_OFS_FLAGS 8'h0C
`define ETC_OFS_IRQEN 8'h10
// Control field positions.
`define ETC_CS_LSB 0
`define ETC_CS_MSB 2
`define ETC_WGM_LSB 3
`define ETC_WGM_MSB 4
`define ETC_COM_LSB 5
`define ETC_COM_MSB 6
`define ETC_FOC_BIT 7
// Flag and enable bit positions.
`define ETC_OVF_BIT 0
`define ETC_CMP_BIT 1
// Counter extremes.
`define ETC_BOTTOM 8'h00
`define ETC_MAX 8'hFF
// Reset values.
`define ETC_RST_BYTE 8'h00
// Prescaler terminal counts for divide by 8, 64, 256 and 1024.
`define ETC_PRE_8 10'h007
`define ETC_PRE_64 10'h03F
`define ETC_PRE_256 10'h0FF
`define ETC_PRE_1024 10'h3FF
`endif

/* shared/etc_pkg.sv */
`default_nettype none
package etc_pkg;
    // Waveform modes.
    typedef enum logic [1:0] {
        ETC_WG_NORMAL = 2'h0,
        ETC_WG_PCPWM = 2'h1,
        ETC_WG_CTC = 2'h2,
        ETC_WG_FAST = 2'h3
    } etc_wave_t;
    // Count direction, one-hot.
    typedef enum logic [1:0] {
        ETC_DIR_UP = 2'b01,
        ETC_DIR_DOWN = 2'b10
    } etc_dir_t;
    // Output actions in non-PWM modes.
    typedef enum logic [1:0] {
        ETC_ACT_NONE = 2'h0,
        ETC_ACT_TOGGLE = 2'h1,
        ETC_ACT_CLEAR = 2'h2,
        ETC_ACT_SET = 2'h3
    } etc_act_t;
endpackage
`default_nettype wire

/* rtl/etc_tick_sel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "etc_params.svh"
// Builds the timer tick from the prescaler or the external input.
module etc_tick_sel (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [2:0] sel,
    input wire logic ext_tick_in,
    output logic tick
);
    logic [9:0] pre_q; // Free-running prescaler.
    logic ext_q; // Previous external level.

    // The prescaler runs always so a new selection starts promptly.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= 10'h000;
        end else begin
            pre_q <= pre_q + 10'h001;
        end
    end

    // Remembers the external level for edge detection.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= ext_tick_in;
        end
    end

    // Selection zero yields no tick, so the counter stands still.
    always_comb begin
        case (sel)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = ((pre_q & `ETC_PRE_8) == `ETC_PRE_8);
            3'h3: tick = ((pre_q & `ETC_PRE_64) == `ETC_PRE_64);
            3'h4: tick = ((pre_q & `ETC_PRE_256) == `ETC_PRE_256);
            3'h5: tick = (pre_q == `ETC_PRE_1024);
            3'h6: tick = ext_q & ~ext_tick_in;
            default: tick = ~ext_q & ext_tick_in;
        endcase
    end
endmodule
`default_nettype wire

/* rtl/etc_out_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// Holds the compare-output register and drives the pin override.
module etc_out_unit (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] mode,
    input wire logic [1:0] action,
    input wire logic match_evt,
    input wire logic bottom_evt,
    input wire logic force_evt,
    input wire logic dir_up,
    input wire logic port_out_value,
    input wire logic output_pin_direction_bit,
    output logic compare_output,
    output logic pin_o,
    output logic pin_oe_n
);
    logic oc_d; // Next output state.

    // Next output state per mode; the action field is read live.
    always_comb begin
        oc_d = compare_output;
        case (mode)
            2'h1: begin
                // Phase correct: clear up, set down when non-inverted.
                if (match_evt && action[1]) begin
                    oc_d = action[0] ^ ~dir_up;
                end
            end
            2'h3: begin
                // Fast PWM: match action, then bottom has the final word.
                if (match_evt && action == 2'h1) begin
                    oc_d = ~compare_output;
                end else if (match_evt && action[1]) begin
                    oc_d = action[0];
                end
                if (bottom_evt && action[1]) begin
                    oc_d = ~action[0];
                end
            end
            default: begin
                // Normal and clear-on-match: toggle, clear or set.
                if (match_evt || force_evt) begin
                    case (action)
                        2'h1: oc_d = ~compare_output;
                        2'h2: oc_d = 1'b0;
                        2'h3: oc_d = 1'b1;
                        default: oc_d = compare_output;
                    endcase
                end
            end
        endcase
    end

    // Mode changes do not touch the register; only reset or an output event changes it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_output <= 1'b0;
        end else begin
            compare_output <= oc_d;
        end
    end

    // Any nonzero action overrides the port; direction stays with the port.
    assign pin_o = (action != 2'h0) ? compare_output : port_out_value;
    assign pin_oe_n = ~output_pin_direction_bit;

    act_none_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (action == 2'h0) |=> (compare_output == $past(compare_output)))
        else $error("output changed with no action selected");
endmodule
`default_nettype wire

/* dv/etc_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "etc_params.svh"
// Drives the timer over its register bus and judges what comes back.
module tb;
    logic hclk = 1'b0; // System clock, 100 MHz.
    logic hresetn = 1'b0; // Active-low reset.
    logic hsel = 1'b0; // Bus select.
    logic hwrite = 1'b0; // Bus direction.
    logic [1:0] htrans = 2'b00; // Transfer type.
    logic [31:0] haddr = 32'h0000_0000; // Bus address.
    logic [31:0] hwdata = 32'h0000_0000; // Write data.
    logic [31:0] hrdata; // Read data.
    logic hreadyout; // Slave ready, fed back as bus ready.
    logic hresp; // Slave response.
    logic glb = 1'b0; // Global interrupt enable.
    logic ovf_ack = 1'b0; // Overflow service pulse.
    logic port_v = 1'b0; // Normal port value.
    logic dir = 1'b0; // Pin direction bit.
    logic cmp_ack = 1'b0; // Compare service pulse.
    logic ext = 1'b0; // External tick level.
    logic cmp_req, ovf_req, pin_o, pin_oe_n; // Observed outputs.
    logic [31:0] q; // Last read value.
    int n_errors = 0; // Mismatches seen.
    int checks_done = 0; // Comparisons made.
    int cyc = 0; // Cycle count for the hang limit.

    // The device under test, one slave on the bus.
    etc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ext_tick_in(ext), .global_irq_en(glb), .cmp_irq_ack(cmp_ack),
        .ovf_irq_ack(ovf_ack), .cmp_irq_req(cmp_req), .ovf_irq_req(ovf_req),
        .port_out_value(port_v), .output_pin_direction_bit(dir),
        .compare_output_pin_o(pin_o), .compare_output_pin_oe_n(pin_oe_n));

    // Clock generator.
    always #5 hclk = ~hclk;

    // Cuts a hang short well after the tests should have ended.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            close_out();
        end
    end

    // Prints the counts and the verdict, then stops.
    task close_out;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t: got %h want %h", $time, g, e);
        end
    endtask

    // One single transfer: address phase, then data phase, both held until ready.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // Control word from its fields.
    function automatic logic [31:0] ctl(logic [2:0] cs, logic [1:0] wg, logic [1:0] ac,
        logic fc);
        return {24'h00_0000, fc, ac, wg, cs};
    endfunction

    // Reset values of every register, the response and the pin.
    task t_reset;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0000_0000);
            chk(q, 32'h0000_0000);
        end
        chk({29'h0000_0000, hreadyout, pin_oe_n, hresp}, 32'h0000_0006);
        $display("reset test done");
    endtask

    // A stopped counter keeps a written value.
    task t_stop;
        bus(1'b1, `ETC_OFS_COUNT, 32'h0000_005A);
        repeat (20) @(posedge hclk);
        bus(1'b0, `ETC_OFS_COUNT, 32'h0000_0000);
        chk(q, 32'h0000_005A);
        bus(1'b1, `ETC_OFS_CTRL, ctl(3'h7, 2'h0, 2'h0, 1'b0));
        for (int i = 0; i < 6; i++) begin
            @(posedge hclk);
            ext <= ~ext;
        end
        bus(1'b0, `ETC_OFS_COUNT, 32'h0000_0000);
        chk(q, 32'h0000_005D);
        $display("stop test done");
    endtask

    // Normal mode wraps, sets overflow and the service pulse clears it.
    task t_wrap;
        glb <= 1'b1;
        bus(1'b1, `ETC_OFS_IRQEN, 32'h0000_0003);
        bus(1'b1, `ETC_OFS_COUNT, 32'h0000_00FD);
        bus(1'b1, `ETC_OFS_CTRL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
        repeat (10) @(posedge hclk);
        bus(1'b0, `ETC_OFS_FLAGS, 32'h0000_0000);
        chk(q & 32'h0000_0001, 32'h0000_0001);
        chk({31'h0000_0000, ovf_req}, 32'h0000_0001);
        bus(1'b0, `ETC_OFS_COUNT, 32'h0000_0000);
        chk({31'h0000_0000, q < 32'h0000_0020}, 32'h0000_0001);
        @(posedge hclk);
        ovf_ack <= 1'b1;
        @(posedge hclk);
        ovf_ack <= 1'b0;
        bus(1'b0, `ETC_OFS_FLAGS, 32'h0000_0000);
        chk(q & 32'h0000_0001, 32'h0000_0000);
        $display("wrap test done");
    endtask

    // A counter write equal to compare blocks the first match only.
    task t_cmp;
        bus(1'b1, `ETC_OFS_CTRL, 32'h0000_0000);
        bus(1'b1, `ETC_OFS_FLAGS, 32'h0000_0003);
        bus(1'b1, `ETC_OFS_COMPARE, 32'h0000_0040);
        bus(1'b1, `ETC_OFS_COUNT, 32'h0000_0040);
        bus(1'b1, `ETC_OFS_CTRL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
        bus(1'b0, `ETC_OFS_FLAGS, 32'h0000_0000);
        chk(q & 32'h0000_0002, 32'h0000_0000);
        repeat (262) @(posedge hclk);
        bus(1'b0, `ETC_OFS_FLAGS, 32'h0000_0000);
        chk(q & 32'h0000_0002, 32'h0000_0002);
        chk({31'h0000_0000, cmp_req}, 32'h0000_0001);
        glb <= 1'b0;
        bus(1'b1, `ETC_OFS_FLAGS, 32'h0000_0000);
        chk({31'h0000_0000, cmp_req}, 32'h0000_0000);
        bus(1'b0, `ETC_OFS_FLAGS, 32'h0000_0000);
        chk(q & 32'h0000_0002, 32'h0000_0002);
        bus(1'b1, `ETC_OFS_FLAGS, 32'h0000_0002);
        bus(1'b0, `ETC_OFS_FLAGS, 32'h0000_0000);
        chk(q & 32'h0000_0002, 32'h0000_0000);
        $display("compare test done");
    endtask

    // Forced matches in clear-on-match mode for toggle, clear and set, then the override.
    task t_force;
        logic [1:0] ac;
        bus(1'b1, `ETC_OFS_CTRL, 32'h0000_0000);
        bus(1'b1, `ETC_OFS_FLAGS, 32'h0000_0003);
        for (int i = 1; i < 4; i++) begin
            ac = 2'(i);
            bus(1'b1, `ETC_OFS_CTRL, ctl(3'h0, 2'h2, ac, 1'b1));
            repeat (3) @(posedge hclk);
            chk({30'h0000_0000, pin_o, pin_oe_n}, {30'h0000_0000, i != 2, 1'b1});
        end
        dir <= 1'b1;
        bus(1'b0, `ETC_OFS_FLAGS, 32'h0000_0000);
        chk(q & 32'h0000_0002, 32'h0000_0000);
        bus(1'b1, `ETC_OFS_CTRL, ctl(3'h0, 2'h0, 2'h3, 1'b0));
        @(negedge hclk);
        chk({30'h0000_0000, pin_o, pin_oe_n}, 32'h0000_0002);
        bus(1'b1, `ETC_OFS_CTRL, 32'h0000_0000);
        @(negedge hclk);
        chk({31'h0000_0000, pin_o}, 32'h0000_0000);
        bus(1'b1, `ETC_OFS_COMPARE, 32'h0000_0010);
        bus(1'b1, `ETC_OFS_COUNT, 32'h0000_0000);
        bus(1'b1, `ETC_OFS_CTRL, ctl(3'h1, 2'h2, 2'h0, 1'b0));
        repeat (100) @(posedge hclk);
        bus(1'b0, `ETC_OFS_COUNT, 32'h0000_0000);
        chk({31'h0000_0000, q < 32'h0000_0011}, 32'h0000_0001);
        $display("force test done");
    endtask

    // Fast PWM holds a new compare value until top; phase correct turns at max.
    task t_pwm;
        bus(1'b1, `ETC_OFS_CTRL, 32'h0000_0000);
        bus(1'b1, `ETC_OFS_COMPARE, 32'h0000_0020);
        bus(1'b1, `ETC_OFS_CTRL, ctl(3'h0, 2'h3, 2'h2, 1'b0));
        bus(1'b1, `ETC_OFS_COMPARE, 32'h0000_0080);
        bus(1'b0, `ETC_OFS_COMPARE, 32'h0000_0000);
        chk(q, 32'h0000_0080);
        bus(1'b1, `ETC_OFS_FLAGS, 32'h0000_0003);
        bus(1'b1, `ETC_OFS_COUNT, 32'h0000_0010);
        bus(1'b1, `ETC_OFS_CTRL, ctl(3'h1, 2'h3, 2'h2, 1'b0));
        repeat (30) @(posedge hclk);
        bus(1'b0, `ETC_OFS_FLAGS, 32'h0000_0000);
        chk(q & 32'h0000_0002, 32'h0000_0002);
        chk({31'h0000_0000, pin_o}, 32'h0000_0000);
        @(posedge hclk);
        cmp_ack <= 1'b1;
        @(posedge hclk);
        cmp_ack <= 1'b0;
        repeat (260) @(posedge hclk);
        bus(1'b0, `ETC_OFS_FLAGS, 32'h0000_0000);
        chk(q & 32'h0000_0002, 32'h0000_0000);
        chk({31'h0000_0000, pin_o}, 32'h0000_0001);
        bus(1'b1, `ETC_OFS_CTRL, ctl(3'h0, 2'h1, 2'h0, 1'b0));
        bus(1'b1, `ETC_OFS_COUNT, 32'h0000_00FD);
        bus(1'b1, `ETC_OFS_CTRL, ctl(3'h1, 2'h1, 2'h0, 1'b0));
        repeat (5) @(posedge hclk);
        bus(1'b0, `ETC_OFS_COUNT, 32'h0000_0000);
        chk(q, 32'h0000_00FB);
        $display("pwm test done");
    endtask

    // Main sequence: reset for two cycles, then each scenario in turn.
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_stop();
        t_wrap();
        t_cmp();
        t_force();
        t_pwm();
        close_out();
    end
endmodule
`default_nettype wire
